/* File: inc/fsbp_consts.svh */
/*
  Constants for the flash status byte and block protection logic.
  Assumes inclusion by bare name from design files.
*/
`ifndef FSBP_CONSTS_SVH
`define FSBP_CONSTS_SVH

// Status byte field positions
`define FSBP_BIT_SRWD 7
`define FSBP_BIT_BP3 6
`define FSBP_BIT_TB 5
`define FSBP_BIT_BP_HI 4
`define FSBP_BIT_BP_LO 2
`define FSBP_BIT_WEL 1
`define FSBP_BIT_BUSY 0
// Flag status byte field positions
`define FSBP_FLAG_READY 7
`define FSBP_FLAG_ERASE_ERR 5
`define FSBP_FLAG_PROG_ERR 4
`define FSBP_FLAG_PROT_ERR 1
// Nonvolatile reset image: disable bit 1, bottom 1, protect code 0
`define FSBP_NV_RESET 8'hA0
`define FSBP_NV_MASK 8'hFC
// Sector geometry
`define FSBP_SECTOR_SHIFT 16
`define FSBP_SECTOR_BITS 11
`define FSBP_ADDR_BITS 27
`define FSBP_CODE_ALL 4'hC
// Default internal cycle lengths in clock cycles
`define FSBP_WRSR_CYCLES 16'h0010
`define FSBP_PROG_CYCLES 16'h0040
`define FSBP_ERASE_CYCLES 16'h0100

`endif

/* File: inc/fsbp_pkg.sv */
/*
  Types for the flash status byte and block protection logic.
  Assumes no other package.
*/
package fsbp_pkg;
  // Commands presented by the command decoder, one-hot
  typedef enum logic [6:0] {
    FSBP_CMD_NONE = 7'h00,
    FSBP_CMD_WREN = 7'h01,
    FSBP_CMD_WRDI = 7'h02,
    FSBP_CMD_WRSR = 7'h04,
    FSBP_CMD_PROG = 7'h08,
    FSBP_CMD_SECT_ERASE = 7'h10,
    FSBP_CMD_DIE_ERASE = 7'h20,
    FSBP_CMD_CLR_FLAGS = 7'h40
  } fsbp_cmd_t;

  // Internal cycle state, one-hot
  typedef enum logic [1:0] {
    FSBP_ST_IDLE = 2'b01,
    FSBP_ST_BUSY = 2'b10
  } fsbp_state_t;
endpackage

/* File: rtl/fsbp_range_decode.sv */
/*
  Combinational protected-range test for one sector index.
  Assumes the status bits are stable registers of the same clock.
*/
`timescale 1ns/1ps
`include "fsbp_consts.svh"

module fsbp_range_decode #(
  parameter int SECTOR_BITS = `FSBP_SECTOR_BITS
) (
  // Protection settings
  input wire logic [3:0] protectCode,
  input wire logic bottomSel,
  // Sector under test
  input wire logic [SECTOR_BITS-1:0] sectorIdx,
  // Result
  output logic isProtected
);
  logic [SECTOR_BITS:0] span;
  logic [SECTOR_BITS-1:0] offsetIdx;

  always_comb begin
    span = '0;
    offsetIdx = bottomSel ? sectorIdx : ~sectorIdx;
    if (protectCode == 4'h0) begin
      isProtected = 1'b0;
    end else if (protectCode >= `FSBP_CODE_ALL) begin
      isProtected = 1'b1;
    end else begin
      // Region holds 2^(n-1) sectors counted from the anchor end
      span = (SECTOR_BITS+1)'(1) << (protectCode - 4'h1);
      isProtected = {1'b0, offsetIdx} < span;
    end
  end
endmodule // fsbp_range_decode

/* File: rtl/fsbp_cycle_timer.sv */
/*
  Down-counter timing one internal program, erase or status write cycle.
  Assumes a one-cycle start pulse with a length loaded alongside it.
*/
`timescale 1ns/1ps

module fsbp_cycle_timer #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic start,
  input wire logic [WIDTH-1:0] length,
  // Result
  output logic done
);
  logic [WIDTH-1:0] count_r;
  logic running_r;

  // Count down to one, then report done for a cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      count_r <= '0;
      running_r <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_r <= (length == '0) ? WIDTH'(1) : length;
        running_r <= 1'b1;
      end else if (running_r) begin
        if (count_r == WIDTH'(1)) begin
          running_r <= 1'b0;
          done <= 1'b1;
        end
        count_r <= count_r - WIDTH'(1);
      end
    end
  end
endmodule // fsbp_cycle_timer

/* File: rtl/fsbp_status_protect.sv */
/*
  Status byte, flag byte and block protection for a serial NOR flash.
  Assumes a command decoder on the same clock presents one-cycle
  command pulses with address and data; the write-protect pin is async.
*/
// Functional notes
// - Read-status returns the status byte; write-status loads it when permitted.
// - Disable bit set with write-protect pin low makes status writes ignored.
// - Only raising the write-protect pin leaves hardware-protected status.
// - Bit 7 is nonvolatile status-write disable, default one.
// - Bit 5 picks top (0) or bottom (1, default) anchor.
// - Protect field at bits 6 and 4:2 blocks program/erase in region.
// - Write-enable latch bit 1 clears at reset, sets on write-enable.
// - Busy bit 0 high during any internal write, program or erase cycle.
// - Busy bit always equals inverse of flag ready bit 7.
// - Die erase runs only when every protect bit is zero.
// - Top anchor: code n protects highest 2^(n-1) sectors; 12-15 all.
// - Bottom anchor: code n protects lowest 2^(n-1) sectors; 12-15 all.
// - Program or erase on protected sector sets protection error flag.
// - Error flags stay set until the clear-flags command.
`timescale 1ns/1ps
`include "fsbp_consts.svh"

module fsbp_status_protect #(
  parameter int ADDR_BITS = `FSBP_ADDR_BITS,
  parameter int SECTOR_BITS = `FSBP_SECTOR_BITS,
  parameter logic [15:0] WRSR_CYCLES = `FSBP_WRSR_CYCLES,
  parameter logic [15:0] PROG_CYCLES = `FSBP_PROG_CYCLES,
  parameter logic [15:0] ERASE_CYCLES = `FSBP_ERASE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Write-protect pin, active low
  input wire logic writeProtectN,
  // Command from decoder
  input wire logic cmdValid,
  input wire fsbp_pkg::fsbp_cmd_t cmdCode,
  input wire logic [ADDR_BITS-1:0] cmdAddr,
  input wire logic [7:0] cmdData,
  // Register views
  output logic [7:0] statusByte,
  output logic [7:0] flagByte,
  // Array operation control
  output logic arrayOpStart,
  output logic arrayOpErase,
  output logic arrayOpDie,
  output logic [ADDR_BITS-1:0] arrayOpAddr,
  output logic cmdRejected
);
  // Pin synchroniser
  logic wpMeta_r;
  logic wpSync_r;
  // Nonvolatile image and volatile state
  logic [7:0] nvStatus_r;
  logic [7:0] nvStatus_nxt;
  logic wel_r;
  fsbp_pkg::fsbp_state_t state_r;
  logic busyWrsr_r;
  logic [7:0] pendStatus_r;
  logic progErr_r;
  logic eraseErr_r;
  logic protErr_r;
  // Decode
  logic [3:0] protectCode;
  logic bottomSel;
  logic targetProtected;
  logic hwLocked;
  logic idle;
  logic cmdWrsr;
  logic cmdProg;
  logic cmdSect;
  logic cmdDie;
  logic anyArrayCmd;
  logic arrayDeny;
  logic arrayOk;
  logic wrsrOk;
  logic timerStart;
  logic [15:0] timerLength;
  logic timerDone;
  // Strobes decoded once, used by several processes
  logic cmdWren;
  logic cmdWrdi;
  logic cmdClr;
  logic protHit;
  logic wrsrCommit;

  // Pull the protect code out of a status image
  // Field is split around the anchor bit
  function automatic logic [3:0] protectField(input logic [7:0] s);
    protectField = {s[`FSBP_BIT_BP3], s[`FSBP_BIT_BP_HI:`FSBP_BIT_BP_LO]};
  endfunction

  // Command strobe decode, shared by every command
  function automatic logic cmdIs(input logic v, input fsbp_pkg::fsbp_cmd_t c, input fsbp_pkg::fsbp_cmd_t want);
    cmdIs = v && (c == want);
  endfunction

  // Two-flop synchroniser for the write-protect pin
  // Resets to the asserted level, so writes wait two cycles after reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wpMeta_r <= 1'b0;
      wpSync_r <= 1'b0;
    end else begin
      wpMeta_r <= writeProtectN;
      wpSync_r <= wpMeta_r;
    end
  end

  assign protectCode = protectField(nvStatus_r);
  assign bottomSel = nvStatus_r[`FSBP_BIT_TB];

  // sector index from address
  // Low address bits only pick a byte inside the sector
  fsbp_range_decode #(
    .SECTOR_BITS(SECTOR_BITS)
  ) u_range (
    .protectCode(protectCode),
    .bottomSel(bottomSel),
    .sectorIdx(cmdAddr[`FSBP_SECTOR_SHIFT +: SECTOR_BITS]),
    .isProtected(targetProtected)
  );

  // lock holds only while pin is low
  // A pin pulse shorter than a cycle may be missed by the synchroniser
  assign hwLocked = nvStatus_r[`FSBP_BIT_SRWD] && !wpSync_r;
  assign idle = (state_r == fsbp_pkg::FSBP_ST_IDLE);

  // Command strobes, at most one per cycle
  assign cmdWrsr = cmdIs(cmdValid, cmdCode, fsbp_pkg::FSBP_CMD_WRSR);
  assign cmdProg = cmdIs(cmdValid, cmdCode, fsbp_pkg::FSBP_CMD_PROG);
  assign cmdSect = cmdIs(cmdValid, cmdCode, fsbp_pkg::FSBP_CMD_SECT_ERASE);
  assign cmdDie = cmdIs(cmdValid, cmdCode, fsbp_pkg::FSBP_CMD_DIE_ERASE);
  assign cmdWren = cmdIs(cmdValid, cmdCode, fsbp_pkg::FSBP_CMD_WREN);
  assign cmdWrdi = cmdIs(cmdValid, cmdCode, fsbp_pkg::FSBP_CMD_WRDI);
  assign cmdClr = cmdIs(cmdValid, cmdCode, fsbp_pkg::FSBP_CMD_CLR_FLAGS);
  assign anyArrayCmd = cmdProg || cmdSect || cmdDie;

  assign arrayDeny = cmdDie ? (protectCode != 4'h0) : targetProtected;
  assign arrayOk = anyArrayCmd && idle && wel_r && !arrayDeny;
  assign wrsrOk = cmdWrsr && idle && wel_r && !hwLocked;

  // only a protection hit flags; a missing latch refuses silently
  assign protHit = anyArrayCmd && idle && wel_r && arrayDeny;

  // merge written data into nonvolatile bits only
  assign nvStatus_nxt = (nvStatus_r & ~8'(`FSBP_NV_MASK)) | (cmdData & 8'(`FSBP_NV_MASK));

  // Internal cycle start and length
  // Length is a don't-care on cycles where nothing starts
  assign timerStart = arrayOk || wrsrOk;
  always_comb begin
    if (wrsrOk) begin
      timerLength = WRSR_CYCLES;
    end else if (cmdProg) begin
      timerLength = PROG_CYCLES;
    end else begin
      timerLength = ERASE_CYCLES;
    end
  end

  fsbp_cycle_timer #(
    .WIDTH(16)
  ) u_timer (
    .clk(clk),
    .resetn(resetn),
    .start(timerStart),
    .length(timerLength),
    .done(timerDone)
  );

  // internal cycle state
  // Status writes and array operations share one timer and one busy flag
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= fsbp_pkg::FSBP_ST_IDLE;
      busyWrsr_r <= 1'b0;
      pendStatus_r <= 8'h00;
    end else begin
      unique case (state_r)
        fsbp_pkg::FSBP_ST_IDLE: begin
          if (timerStart) begin
            state_r <= fsbp_pkg::FSBP_ST_BUSY;
            busyWrsr_r <= wrsrOk;
            pendStatus_r <= nvStatus_nxt;
          end
        end
        fsbp_pkg::FSBP_ST_BUSY: begin
          if (timerDone) begin
            state_r <= fsbp_pkg::FSBP_ST_IDLE;
            busyWrsr_r <= 1'b0;
          end
        end
        default: begin
          state_r <= fsbp_pkg::FSBP_ST_IDLE;
        end
      endcase
    end
  end

  // Commit only a status write that ran its whole cycle
  assign wrsrCommit = (state_r == fsbp_pkg::FSBP_ST_BUSY) && timerDone && busyWrsr_r;

  // nonvolatile image, committed at end of status write
  // Reset reloads the default image; there is no real nonvolatile store
  always_ff @(posedge clk) begin
    if (!resetn) begin
      nvStatus_r <= 8'(`FSBP_NV_RESET);
    end else if (wrsrCommit) begin
      nvStatus_r <= pendStatus_r;
    end
  end

  // write-enable latch; consumed by accepted writes, dropped by disable
  // A refused command leaves the latch set, so the host may retry
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wel_r <= 1'b0;
    end else if (cmdWren && idle) begin
      wel_r <= 1'b1;
    end else if (cmdWrdi && idle) begin
      wel_r <= 1'b0;
    end else if (timerDone) begin
      wel_r <= 1'b0;
    end
  end

  // protection error, a new error wins over clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      protErr_r <= 1'b0;
    end else if (protHit) begin
      protErr_r <= 1'b1;
    end else if (cmdClr && idle) begin
      protErr_r <= 1'b0;
    end
  end

  // program error, raised beside the protection error
  always_ff @(posedge clk) begin
    if (!resetn) begin
      progErr_r <= 1'b0;
    end else if (protHit && cmdProg) begin
      progErr_r <= 1'b1;
    end else if (cmdClr && idle) begin
      progErr_r <= 1'b0;
    end
  end

  // erase error, sector and die erase alike
  always_ff @(posedge clk) begin
    if (!resetn) begin
      eraseErr_r <= 1'b0;
    end else if (protHit && (cmdSect || cmdDie)) begin
      eraseErr_r <= 1'b1;
    end else if (cmdClr && idle) begin
      eraseErr_r <= 1'b0;
    end
  end

  // status view; busy comes from the same idle flop as ready
  always_ff @(posedge clk) begin
    if (!resetn) begin
      statusByte <= 8'(`FSBP_NV_RESET);
    end else begin
      statusByte <= {nvStatus_r[7:2], wel_r, !idle};
    end
  end

  // flag view; one source keeps busy and ready exact inverses
  always_ff @(posedge clk) begin
    if (!resetn) begin
      flagByte <= 8'h80;
    end else begin
      flagByte <= {idle, 1'b0, eraseErr_r, progErr_r, 2'b00, protErr_r, 1'b0};
    end
  end

  // Launch and refusal pulses, one cycle each
  always_ff @(posedge clk) begin
    if (!resetn) begin
      arrayOpStart <= 1'b0;
      cmdRejected <= 1'b0;
    end else begin
      arrayOpStart <= arrayOk;
      // Busy, no latch, lock or protection all refuse alike
      cmdRejected <= (anyArrayCmd || cmdWrsr) && !(arrayOk || wrsrOk);
    end
  end

  // Kind and target of the last accepted operation, held until the next
  always_ff @(posedge clk) begin
    if (!resetn) begin
      arrayOpErase <= 1'b0;
      arrayOpDie <= 1'b0;
      arrayOpAddr <= '0;
    end else if (arrayOk) begin
      arrayOpErase <= cmdSect || cmdDie;
      arrayOpDie <= cmdDie;
      arrayOpAddr <= cmdAddr;
    end
  end
endmodule // fsbp_status_protect

/* File: tb/fsbp_host_model.sv */
/* Host side command driver for the status block.
   Assumes one bench process calls its tasks. */
`timescale 1ns/1ps
module fsbp_host_model (
  // Clock
  input wire logic clk,
  // Command lines
  output logic cmdValid,
  output fsbp_pkg::fsbp_cmd_t cmdCode,
  output logic [26:0] cmdAddr,
  output logic [7:0] cmdData
);
  initial begin
    cmdValid = 1'b0;
    cmdCode = fsbp_pkg::FSBP_CMD_NONE;
    cmdAddr = 27'h0;
    cmdData = 8'h0;
  end
  // One pulse; idle address and data lines carry inverted junk so stale data never matches, while cmdCode keeps the last command
  task automatic send(input fsbp_pkg::fsbp_cmd_t c, input logic [26:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    cmdValid = 1'b1;
    cmdCode = c;
    cmdAddr = a;
    cmdData = d;
    @(posedge clk) #1;
    cmdValid = 1'b0;
    cmdAddr = ~a;
    cmdData = ~d;
  endtask
  task automatic guarded(input fsbp_pkg::fsbp_cmd_t c, input logic [26:0] a, input logic [7:0] d);
    send(fsbp_pkg::FSBP_CMD_WREN, 27'h0, 8'h0);
    send(c, a, d);
  endtask
endmodule // fsbp_host_model

/* File: tb/fsbp_status_props.sv */
/* Port checker for the status block.
   Assumes the bind below and default widths. */
`timescale 1ns/1ps
module fsbp_status_props (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Inputs
  input wire logic writeProtectN,
  input wire logic cmdValid,
  input wire fsbp_pkg::fsbp_cmd_t cmdCode,
  // Outputs
  input wire logic [7:0] statusByte,
  input wire logic [7:0] flagByte,
  input wire logic arrayOpStart,
  input wire logic arrayOpDie,
  input wire logic cmdRejected
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Command decode helpers
  wire logic isWrsr = cmdValid && cmdCode == fsbp_pkg::FSBP_CMD_WRSR;
  wire logic isClr = cmdValid && cmdCode == fsbp_pkg::FSBP_CMD_CLR_FLAGS;
  AST_BUSY_INVERSE: assert property (statusByte[0] == !flagByte[7])
    else $error("busy and ready disagree");
  AST_RESET_IMAGE: assert property ($rose(resetn) |-> statusByte == 8'hA0 && flagByte == 8'h80)
    else $error("reset image wrong");
  AST_NO_WEL_REFUSE: assert property (cmdValid && cmdCode == fsbp_pkg::FSBP_CMD_PROG
    && !statusByte[1] && !$past(cmdValid) |=> cmdRejected && !arrayOpStart) else $error("program without enable");
  AST_LOCK_REFUSE: assert property (isWrsr && statusByte[7] && !writeProtectN && !$past(writeProtectN)
    && !$past(writeProtectN, 2) && !$past(statusByte[0]) |=> cmdRejected) else $error("locked write taken");
  AST_NV_AT_END: assert property ($changed(statusByte[7:2]) |-> $past(statusByte[0]))
    else $error("status bits moved while idle");
  AST_START_BUSY: assert property (arrayOpStart |=> statusByte[0] && !flagByte[7])
    else $error("no busy after start");
  AST_BUSY_ENDS: assert property ($rose(statusByte[0]) |-> ##[2:300] !statusByte[0])
    else $error("busy never ends");
  AST_DIE_CLEAN: assert property (arrayOpStart && arrayOpDie |-> statusByte[6] == 1'h0 && statusByte[4:2] == 3'h0)
    else $error("die erase with protection");
  AST_FLAG_STICKY: assert property (flagByte[1] && !isClr && !$past(isClr) |=> flagByte[1])
    else $error("error flag dropped");
  // Main scenarios reached
  cover property (isWrsr && !writeProtectN ##1 cmdRejected);
  cover property (arrayOpStart && arrayOpDie);
  cover property ($rose(flagByte[1]));
endmodule // fsbp_status_props
bind fsbp_status_protect fsbp_status_props u_props (.clk(clk), .resetn(resetn), .writeProtectN(writeProtectN),
  .cmdValid(cmdValid), .cmdCode(cmdCode), .statusByte(statusByte), .flagByte(flagByte),
  .arrayOpStart(arrayOpStart), .arrayOpDie(arrayOpDie), .cmdRejected(cmdRejected));

/* File: tb/tb_flash_status_block_protect.sv */
/* Self-checking bench for the status byte and sector protection.
   Assumes short internal cycles; the host model drives commands. */
`timescale 1ns/1ps
module tb_flash_status_block_protect;
  typedef struct packed {
    logic [7:0] nv;
    logic [10:0] sector;
    logic erase;
    logic prot;
  } fsbp_row_t;
  // Top and bottom edges of codes 1 and 11, top edge of code 8, and codes 12 and 0
  fsbp_row_t rows [12] = '{'{8'h04, 11'h7FF, 1'h0, 1'h1}, '{8'h04, 11'h7FE, 1'h1, 1'h0},
    '{8'h4C, 11'h400, 1'h0, 1'h1}, '{8'h4C, 11'h3FF, 1'h1, 1'h0}, '{8'h40, 11'h780, 1'h1, 1'h1},
    '{8'h40, 11'h77F, 1'h0, 1'h0}, '{8'h24, 11'h000, 1'h1, 1'h1}, '{8'h24, 11'h001, 1'h0, 1'h0},
    '{8'h6C, 11'h3FF, 1'h0, 1'h1}, '{8'h6C, 11'h400, 1'h1, 1'h0}, '{8'h50, 11'h000, 1'h1, 1'h1},
    '{8'h20, 11'h7FF, 1'h0, 1'h0}};
  logic clk = 1'b0;
  logic resetn;
  logic writeProtectN;
  logic cmdValid;
  fsbp_pkg::fsbp_cmd_t cmdCode;
  logic [26:0] cmdAddr, arrayOpAddr;
  logic [7:0] cmdData, statusByte, flagByte;
  logic arrayOpStart, arrayOpErase, arrayOpDie, cmdRejected;
  int n_errors = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  fsbp_host_model u_host (.clk(clk), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdAddr(cmdAddr), .cmdData(cmdData));
  // Short cycles keep the run brief
  fsbp_status_protect #(.WRSR_CYCLES(16'h0004), .PROG_CYCLES(16'h0004), .ERASE_CYCLES(16'h0006)) u_dut (
    .clk(clk), .resetn(resetn), .writeProtectN(writeProtectN), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .statusByte(statusByte), .flagByte(flagByte),
    .arrayOpStart(arrayOpStart), .arrayOpErase(arrayOpErase), .arrayOpDie(arrayOpDie),
    .arrayOpAddr(arrayOpAddr), .cmdRejected(cmdRejected));
  task automatic chk(input logic [26:0] seen, input logic [26:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded wait for the busy bit to drop
  task automatic wait_idle;
    int k = 0;
    repeat (3) @(posedge clk);
    #1;
    while (statusByte[0] !== 1'b0 && k < 500) begin
      @(posedge clk) #1;
      k++;
    end
    if (k >= 500) n_errors++;
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    wrap_up;
  end
  initial begin
    resetn = 1'b0;
    writeProtectN = 1'b1;
    repeat (8) @(posedge clk);
    #1 resetn = 1'b1;
    chk(statusByte, 8'hA0);
    chk(flagByte, 8'h80);
    repeat (3) @(posedge clk);
    u_host.send(fsbp_pkg::FSBP_CMD_PROG, 27'h0, 8'h0);
    chk(cmdRejected, 1'h1);
    u_host.send(fsbp_pkg::FSBP_CMD_WREN, 27'h0, 8'h0);
    @(posedge clk) #1;
    chk(statusByte, 8'hA2);
    u_host.send(fsbp_pkg::FSBP_CMD_WRDI, 27'h0, 8'h0);
    @(posedge clk) #1;
    chk(statusByte, 8'hA0);
    foreach (rows[i]) begin
      u_host.guarded(fsbp_pkg::FSBP_CMD_WRSR, 27'h0, rows[i].nv);
      wait_idle;
      chk(statusByte, rows[i].nv);
      u_host.guarded(fsbp_pkg::fsbp_cmd_t'(rows[i].erase ? fsbp_pkg::FSBP_CMD_SECT_ERASE : fsbp_pkg::FSBP_CMD_PROG),
        {rows[i].sector, 16'hFFFF}, 8'h0);
      chk(cmdRejected, rows[i].prot);
      chk(arrayOpStart, !rows[i].prot);
      if (!rows[i].prot) begin
        chk(arrayOpAddr, {rows[i].sector, 16'hFFFF});
        chk({arrayOpErase, arrayOpDie}, {rows[i].erase, 1'b0});
      end
      wait_idle;
      chk(flagByte, rows[i].prot ? (rows[i].erase ? 8'hA2 : 8'h92) : 8'h80);
      u_host.send(fsbp_pkg::FSBP_CMD_CLR_FLAGS, 27'h0, 8'h0);
      wait_idle;
      chk(flagByte, 8'h80);
    end
    u_host.guarded(fsbp_pkg::FSBP_CMD_WRSR, 27'h0, 8'h24);
    wait_idle;
    u_host.guarded(fsbp_pkg::FSBP_CMD_DIE_ERASE, 27'h0, 8'h0);
    chk(cmdRejected, 1'h1);
    wait_idle;
    chk(flagByte, 8'hA2);
    u_host.send(fsbp_pkg::FSBP_CMD_CLR_FLAGS, 27'h0, 8'h0);
    wait_idle;
    u_host.guarded(fsbp_pkg::FSBP_CMD_WRSR, 27'h0, 8'hA0);
    wait_idle;
    u_host.guarded(fsbp_pkg::FSBP_CMD_DIE_ERASE, 27'h0, 8'h0);
    chk({arrayOpStart, arrayOpDie}, 2'h3);
    wait_idle;
    writeProtectN = 1'b0;
    repeat (3) @(posedge clk);
    u_host.guarded(fsbp_pkg::FSBP_CMD_WRSR, 27'h0, 8'h00);
    chk(cmdRejected, 1'h1);
    wait_idle;
    chk(statusByte, 8'hA2);
    writeProtectN = 1'b1;
    repeat (3) @(posedge clk);
    u_host.guarded(fsbp_pkg::FSBP_CMD_WRSR, 27'h0, 8'h20);
    wait_idle;
    chk(statusByte, 8'h20);
    u_host.send(fsbp_pkg::FSBP_CMD_WREN, 27'h0, 8'h0);
    @(posedge clk) #1;
    chk(statusByte, 8'h22);
    resetn = 1'b0;
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    chk(statusByte, 8'hA0);
    chk(flagByte, 8'h80);
    wrap_up;
  end
endmodule // tb_flash_status_block_protect
